// [src/ecm_level_monitor_regs.sv]
// Overview of operation
// - Receive-in peak readable as signed 16-bit value per canceller.
// - Send-in peak readable as signed 16-bit value per canceller.
// - Error signal peak readable as signed 16-bit value per canceller.
// - Each value split into two byte registers, separate pair per canceller.
// - High byte in register two, low byte in register one.
// - Second canceller send peak high byte read-only at 2F.
// - Error peak: second at 31/30, first canceller low byte at 10.
// - Threshold high byte read-write at 15 and 35, reset 48.
// - Combined threshold signed 16-bit, default 4800, maximum 7FFF.
//
// AXI4-Lite register bank for two cancellers' level monitors and thresholds.
// Assumes peak strobes are synchronous to aclk; one transfer of each kind.
`timescale 1ns/1ps
`default_nettype none
`include "ecm_cfg.svh"

module ecm_level_monitor_regs
	import ecm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`ECM_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`ECM_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire ecm_peak_t first_peak_in,
	input wire logic first_peak_valid,
	input wire ecm_peak_t second_peak_in,
	input wire logic second_peak_valid,
	output logic signed [15:0] first_doubletalk_threshold,
	output logic signed [15:0] second_doubletalk_threshold
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		ECM_SEL_NONE = 2'h0,
		ECM_SEL_FIRST = 2'h1,
		ECM_SEL_SECOND = 2'h2
	} ecm_sel_t;

	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [7:0] rdata_q;
	logic aw_held_q;
	logic w_held_q;
	logic [`ECM_IDX_W-1:0] waddr_q;
	logic [7:0] wdata_q;
	logic wlane_q;
	logic aw_held_d;
	logic w_held_d;
	logic bvalid_d;
	logic rvalid_d;
	logic aw_fire;
	logic w_fire;
	logic ar_fire;
	logic wr_go;
	ecm_sel_t wsel;
	ecm_sel_t rsel;
	logic [3:0] wloc;
	logic [3:0] rloc;
	ecm_regop_t first_op;
	ecm_regop_t second_op;
	logic [7:0] first_rd;
	logic [7:0] second_rd;
	logic first_rd_hit;
	logic second_rd_hit;
	logic first_wr_hit;
	logic second_wr_hit;
	logic rd_hit;
	logic wr_hit;
	logic [7:0] rd_byte;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Word index split into canceller and local byte register
	function automatic ecm_sel_t decode_sel(input logic [`ECM_IDX_W-1:0] idx);
		logic [`ECM_IDX_W-1:0] span;
		span = {2'h0, `ECM_LOC_SPAN};
		if (idx >= `ECM_FIRST_BASE && idx < `ECM_FIRST_BASE + span)
		begin
			decode_sel = ECM_SEL_FIRST;
		end
		else if (idx >= `ECM_SECOND_BASE && idx < `ECM_SECOND_BASE + span)
		begin
			decode_sel = ECM_SEL_SECOND;
		end
		else
		begin
			decode_sel = ECM_SEL_NONE;
		end
	endfunction

	function automatic logic [3:0] decode_loc(input logic [`ECM_IDX_W-1:0] idx);
		logic [`ECM_IDX_W-1:0] off;
		off = '0;
		case (decode_sel(idx))
			ECM_SEL_FIRST: off = idx - `ECM_FIRST_BASE;
			ECM_SEL_SECOND: off = idx - `ECM_SECOND_BASE;
			default: off = '0;
		endcase
		decode_loc = off[3:0];
	endfunction

	always_comb
	begin
		wsel = decode_sel(waddr_q);
		wloc = decode_loc(waddr_q);
		rsel = decode_sel(s_axi_araddr[`ECM_ADDR_W-1:`ECM_IDX_LSB]);
		rloc = decode_loc(s_axi_araddr[`ECM_ADDR_W-1:`ECM_IDX_LSB]);
	end

	// ----------------------------------------
	// Write channel handshake
	// ----------------------------------------
	// Address and data are taken in either order and paired here
	assign aw_fire = s_axi_awvalid & awready_q;
	assign w_fire = s_axi_wvalid & wready_q;
	assign wr_go = aw_held_q & w_held_q & ~bvalid_q;

	always_comb
	begin
		aw_held_d = (aw_held_q | aw_fire) & ~wr_go;
		w_held_d = (w_held_q | w_fire) & ~wr_go;
		bvalid_d = wr_go | (bvalid_q & ~s_axi_bready);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
		end
		else
		begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awready_q <= ~aw_held_d & ~bvalid_d;
			wready_q <= ~w_held_d & ~bvalid_d;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			waddr_q <= '0;
		end
		else if (aw_fire)
		begin
			waddr_q <= s_axi_awaddr[`ECM_ADDR_W-1:`ECM_IDX_LSB];
		end
	end

	// Registers are eight bits wide, so only the lowest lane matters
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wdata_q <= 8'h00;
			wlane_q <= 1'b0;
		end
		else if (w_fire)
		begin
			wdata_q <= s_axi_wdata[`ECM_BYTE_LO];
			wlane_q <= s_axi_wstrb[0];
		end
	end

	// ----------------------------------------
	// Write response
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= `ECM_RESP_OKAY;
		end
		else
		begin
			bvalid_q <= bvalid_d;
			if (wr_go)
			begin
				bresp_q <= wr_hit ? `ECM_RESP_OKAY : `ECM_RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------
	// Per-canceller write operations
	// ----------------------------------------
	always_comb
	begin
		first_op.we = wr_go & wlane_q & (wsel == ECM_SEL_FIRST);
		first_op.idx = wloc;
		first_op.data = wdata_q;
		second_op.we = wr_go & wlane_q & (wsel == ECM_SEL_SECOND);
		second_op.idx = wloc;
		second_op.data = wdata_q;
	end

	always_comb
	begin
		case (wsel)
			ECM_SEL_FIRST: wr_hit = first_wr_hit;
			ECM_SEL_SECOND: wr_hit = second_wr_hit;
			default: wr_hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Canceller register blocks
	// ----------------------------------------
	ecm_canceller_regs u_first
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.peak_in(first_peak_in),
		.peak_valid(first_peak_valid),
		.wr_op(first_op),
		.rd_idx(rloc),
		.rd_data(first_rd),
		.rd_hit(first_rd_hit),
		.wr_hit(first_wr_hit),
		.threshold(first_doubletalk_threshold)
	);

	ecm_canceller_regs u_second
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.peak_in(second_peak_in),
		.peak_valid(second_peak_valid),
		.wr_op(second_op),
		.rd_idx(rloc),
		.rd_data(second_rd),
		.rd_hit(second_rd_hit),
		.wr_hit(second_wr_hit),
		.threshold(second_doubletalk_threshold)
	);

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	// Data captured at address accept; a later peak refresh shows next read
	assign ar_fire = s_axi_arvalid & arready_q;
	assign rvalid_d = ar_fire | (rvalid_q & ~s_axi_rready);

	always_comb
	begin
		case (rsel)
			ECM_SEL_FIRST:
			begin
				rd_byte = first_rd;
				rd_hit = first_rd_hit;
			end
			ECM_SEL_SECOND:
			begin
				rd_byte = second_rd;
				rd_hit = second_rd_hit;
			end
			default:
			begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= rvalid_d;
			arready_q <= ~rvalid_d;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rdata_q <= 8'h00;
			rresp_q <= `ECM_RESP_OKAY;
		end
		else if (ar_fire)
		begin
			rdata_q <= rd_byte;
			rresp_q <= rd_hit ? `ECM_RESP_OKAY : `ECM_RESP_SLVERR;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = {24'h000000, rdata_q};

endmodule // ecm_level_monitor_regs

`default_nettype wire

// [src/ecm_cfg.svh]
// Address map and reset constants for the echo level monitor register bank.
// Assumes one AXI4-Lite word per 8-bit register, byte address = index * 4.
`ifndef ECM_CFG_SVH
`define ECM_CFG_SVH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define ECM_ADDR_W 8
`define ECM_IDX_LSB 2
`define ECM_IDX_W 6
`define ECM_LOC_W 4
`define ECM_RESP_OKAY 2'h0
`define ECM_RESP_SLVERR 2'h2

// ----------------------------------------
// Register indices, first canceller
// ----------------------------------------
`define ECM_FIRST_BASE 6'h0c
`define ECM_FIRST_RX_PEAK_LO 6'h0c
`define ECM_FIRST_RX_PEAK_HI 6'h0d
`define ECM_FIRST_TX_PEAK_LO 6'h0e
`define ECM_FIRST_TX_PEAK_HI 6'h0f
`define ECM_FIRST_ERR_PEAK_LO 6'h10
`define ECM_FIRST_ERR_PEAK_HI 6'h11
`define ECM_FIRST_DT_LO 6'h14
`define ECM_FIRST_DT_HI 6'h15

// ----------------------------------------
// Register indices, second canceller
// ----------------------------------------
`define ECM_SECOND_BASE 6'h2c
`define ECM_SECOND_RX_PEAK_LO 6'h2c
`define ECM_SECOND_RX_PEAK_HI 6'h2d
`define ECM_SECOND_TX_PEAK_LO 6'h2e
`define ECM_SECOND_TX_PEAK_HI 6'h2f
`define ECM_SECOND_ERR_PEAK_LO 6'h30
`define ECM_SECOND_ERR_PEAK_HI 6'h31
`define ECM_SECOND_DT_LO 6'h34
`define ECM_SECOND_DT_HI 6'h35

// ----------------------------------------
// Offsets inside one canceller's block
// ----------------------------------------
`define ECM_LOC_SPAN 4'ha
`define ECM_LOC_RX_LO 4'h0
`define ECM_LOC_RX_HI 4'h1
`define ECM_LOC_TX_LO 4'h2
`define ECM_LOC_TX_HI 4'h3
`define ECM_LOC_ERR_LO 4'h4
`define ECM_LOC_ERR_HI 4'h5
`define ECM_LOC_DT_LO 4'h8
`define ECM_LOC_DT_HI 4'h9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ECM_DT_HI_RST 8'h48
`define ECM_DT_LO_RST 8'h00
`define ECM_PEAK_RST 16'h0000
`define ECM_BYTE_HI 15:8
`define ECM_BYTE_LO 7:0

`endif

// [src/ecm_pkg.sv]
// Types shared by the echo level monitor register bank.
// Assumes ecm_cfg.svh supplies all numeric constants.
package ecm_pkg;

	// ----------------------------------------
	// Peak levels of one canceller
	// ----------------------------------------
	typedef struct packed
	{
		logic signed [15:0] rx_in;
		logic signed [15:0] tx_in;
		logic signed [15:0] err;
	} ecm_peak_t;

	// ----------------------------------------
	// Byte access into one canceller block
	// ----------------------------------------
	typedef struct packed
	{
		logic we;
		logic [3:0] idx;
		logic [7:0] data;
	} ecm_regop_t;

endpackage

// [src/ecm_canceller_regs.sv]
// Byte registers of one canceller: three peak monitors and the threshold.
// Assumes a single clock and writes already decoded to a local index.
`timescale 1ns/1ps
`default_nettype none
`include "ecm_cfg.svh"

module ecm_canceller_regs
	import ecm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire ecm_peak_t peak_in,
	input wire logic peak_valid,
	input wire ecm_regop_t wr_op,
	input wire logic [3:0] rd_idx,
	output logic [7:0] rd_data,
	output logic rd_hit,
	output logic wr_hit,
	output logic signed [15:0] threshold
);

	ecm_peak_t peak_q;
	logic [7:0] dt_hi_q;
	logic [7:0] dt_lo_q;

	// ----------------------------------------
	// Peak capture
	// ----------------------------------------
	// Refresh wins over a host write to the error low byte
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			peak_q <= '0;
		end
		else if (peak_valid)
		begin
			peak_q <= peak_in;
		end
		else if (wr_op.we && wr_op.idx == `ECM_LOC_ERR_LO)
		begin
			peak_q.err[`ECM_BYTE_LO] <= wr_op.data;
		end
	end

	// ----------------------------------------
	// Double-talk threshold
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dt_hi_q <= `ECM_DT_HI_RST;
			dt_lo_q <= `ECM_DT_LO_RST;
		end
		else if (wr_op.we)
		begin
			if (wr_op.idx == `ECM_LOC_DT_HI)
			begin
				dt_hi_q <= wr_op.data;
			end
			if (wr_op.idx == `ECM_LOC_DT_LO)
			begin
				dt_lo_q <= wr_op.data;
			end
		end
	end

	assign threshold = {dt_hi_q, dt_lo_q};

	// ----------------------------------------
	// Byte read mux, high byte at the odd index
	// ----------------------------------------
	always_comb
	begin
		rd_hit = 1'b1;
		case (rd_idx)
			`ECM_LOC_RX_LO: rd_data = peak_q.rx_in[`ECM_BYTE_LO];
			`ECM_LOC_RX_HI: rd_data = peak_q.rx_in[`ECM_BYTE_HI];
			`ECM_LOC_TX_LO: rd_data = peak_q.tx_in[`ECM_BYTE_LO];
			`ECM_LOC_TX_HI: rd_data = peak_q.tx_in[`ECM_BYTE_HI];
			`ECM_LOC_ERR_LO: rd_data = peak_q.err[`ECM_BYTE_LO];
			`ECM_LOC_ERR_HI: rd_data = peak_q.err[`ECM_BYTE_HI];
			`ECM_LOC_DT_LO: rd_data = dt_lo_q;
			`ECM_LOC_DT_HI: rd_data = dt_hi_q;
			default:
			begin
				rd_data = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read-only bytes still answer OKAY on a write, but store nothing
	always_comb
	begin
		case (wr_op.idx)
			`ECM_LOC_RX_LO,
			`ECM_LOC_RX_HI,
			`ECM_LOC_TX_LO,
			`ECM_LOC_TX_HI,
			`ECM_LOC_ERR_LO,
			`ECM_LOC_ERR_HI,
			`ECM_LOC_DT_LO,
			`ECM_LOC_DT_HI: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

endmodule // ecm_canceller_regs

`default_nettype wire

// [verif/ecm_chk.sv]
// Assertions on the AXI4-Lite side and threshold outputs of the bank.
// Assumes a single aclk domain, bound to ecm_level_monitor_regs.
`timescale 1ns/1ps
`default_nettype none
module ecm_chk
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic signed [15:0] first_doubletalk_threshold,
	input wire logic signed [15:0] second_doubletalk_threshold
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// Handshake steps
	// ----------------------------------------
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// Reset itself is the trigger, so no disable here
	thr_reset_a: assert property (disable iff (1'b0) !aresetn |=>
		first_doubletalk_threshold == 16'h4800 && second_doubletalk_threshold == 16'h4800)
		else $error("threshold not at default after reset");
	wr_resp_a: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response late or early");
	rd_resp_a: assert property (rd_take |=> s_axi_rvalid)
		else $error("read data late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	byte_only_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read accepted");
	// A change outside a write would mean a stray store
	thr1_write_a: assert property ($changed(first_doubletalk_threshold) |-> !s_axi_awready)
		else $error("first threshold changed without a write");
	thr2_write_a: assert property ($changed(second_doubletalk_threshold) |-> !s_axi_wready)
		else $error("second threshold changed without a write");
endmodule // ecm_chk
bind ecm_level_monitor_regs ecm_chk i_ecm_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .first_doubletalk_threshold,
	.second_doubletalk_threshold);
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the level monitor bank over AXI4-Lite.
// Assumes the bank answers within a few cycles; byte address = index * 4.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ecm_pkg::*;
	localparam ecm_peak_t PA = {16'h8123, 16'h7f45, 16'hc3a9};
	localparam ecm_peak_t PB = {16'h0180, 16'hfe7f, 16'h5a00};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	ecm_peak_t first_peak_in = '0;
	ecm_peak_t second_peak_in = '0;
	logic first_peak_valid = 1'b0, second_peak_valid = 1'b0;
	logic signed [15:0] first_doubletalk_threshold, second_doubletalk_threshold;
	int err_total = 0;
	int comparisons = 0;
	int ready_lag = 0;
	always #5 aclk = ~aclk;
	ecm_level_monitor_regs i_ecm_level_monitor_regs (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .first_peak_in, .first_peak_valid, .second_peak_in,
		.second_peak_valid, .first_doubletalk_threshold, .second_doubletalk_threshold);
	// ----------------------------------------
	// Bus tasks and checks
	// ----------------------------------------
	function automatic logic [7:0] ad(input logic [5:0] i);
		return {i, 2'b00};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Ready goes up with the request unless a lag asks for a stalled answer
	task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (ready_lag == 0);
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (n == ready_lag) s_axi_bready <= 1'b1;
		end
		while (!(s_axi_bvalid && s_axi_bready));
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (ready_lag == 0);
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n == ready_lag) s_axi_rready <= 1'b1;
		end
		while (!(s_axi_rvalid && s_axi_rready));
		chk(s_axi_rdata, {24'h000000, e});
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(ad(6'h15), 8'h48, 2'h0);
		rd(ad(6'h14), 8'h00, 2'h0);
		rd(ad(6'h35), 8'h48, 2'h0);
		rd(ad(6'h34), 8'h00, 2'h0);
		chk({16'h0, first_doubletalk_threshold}, 32'h4800);
		chk({16'h0, second_doubletalk_threshold}, 32'h4800);
	endtask
	task automatic t_peaks(input ecm_peak_t p0, input ecm_peak_t p1);
		logic [15:0] v;
		first_peak_in <= p0;
		second_peak_in <= p1;
		first_peak_valid <= 1'b1;
		second_peak_valid <= 1'b1;
		@(posedge aclk);
		first_peak_valid <= 1'b0;
		second_peak_valid <= 1'b0;
		for (int k = 0; k < 12; k++)
		begin
			v = 16'((k < 6 ? p0 : p1) >> (32 - 16 * ((k % 6) / 2)));
			rd(ad((k < 6 ? 6'h0c : 6'h2c) + 6'(k % 6)), k[0] ? v[15:8] : v[7:0], 2'h0);
		end
	endtask
	task automatic t_wr();
		// Late ready makes the answers stand for a few cycles
		ready_lag = 3;
		axw(ad(6'h2f), 8'h00, 4'h1, 2'h0);
		rd(ad(6'h2f), 8'h7f, 2'h0);
		ready_lag = 0;
		axw(ad(6'h10), 8'h3c, 4'h1, 2'h0);
		rd(ad(6'h10), 8'h3c, 2'h0);
		axw(ad(6'h30), 8'h5e, 4'h0, 2'h0);
		rd(ad(6'h30), 8'ha9, 2'h0);
		axw(ad(6'h12), 8'h11, 4'h1, 2'h2);
		rd(ad(6'h33), 8'h00, 2'h2);
		rd(ad(6'h3f), 8'h00, 2'h2);
	endtask
	task automatic t_thr();
		axw(ad(6'h15), 8'h7f, 4'h1, 2'h0);
		axw(ad(6'h14), 8'hff, 4'h1, 2'h0);
		axw(ad(6'h35), 8'h80, 4'h1, 2'h0);
		axw(ad(6'h34), 8'h01, 4'h1, 2'h0);
		axw(ad(6'h35), 8'h22, 4'h0, 2'h0);
		chk({16'h0, first_doubletalk_threshold}, 32'h7fff);
		chk({16'h0, second_doubletalk_threshold}, 32'h8001);
		rd(ad(6'h35), 8'h80, 2'h0);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({16'h0, first_doubletalk_threshold}, 32'h4800);
		rd(ad(6'h34), 8'h00, 2'h0);
	endtask
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_peaks(PA, PB);
		t_peaks(PB, PA);
		t_wr();
		t_thr();
		conclude();
	end
	// Forty-four transfers of under ten cycles each fit well inside this span
	initial
	begin
		#100000;
		err_total++;
		conclude();
	end
endmodule // tb_top
`default_nettype wire
